// file: sync_ctl_pkg.sv
package sync_ctl_pkg;

    // Bus addresses (8-bit form, R/W in bit 0)
    localparam logic [7:0] DEV_ADDR_WR = 8'h8C;
    localparam logic [7:0] DEV_ADDR_RD = 8'h8D;

    // Register file shape
    localparam int NUM_REGS = 16;
    localparam logic [3:0] SUB_FREE_RUN = 4'h2;
    localparam logic [3:0] SUB_SYNC_PRIO = 4'h3;
    localparam logic [3:0] SUB_REFRESH = 4'h4;
    localparam logic [3:0] SUB_XRAY = 4'h1;
    localparam int CTL_BIT = 7;

    // Register defaults after supply reset, subaddress 0..F
    localparam logic [7:0] REG_DEFAULTS [NUM_REGS] = '{
        8'h40, 8'h40, 8'h00, 8'h80, 8'h40, 8'hC0, 8'h40, 8'h20,
        8'h20, 8'hA0, 8'h40, 8'hC0, 8'h00, 8'hA0, 8'hA0, 8'h20
    };

    // Status byte bit positions
    localparam int ST_HLOCK = 7;
    localparam int ST_VLOCK = 6;
    localparam int ST_XRAY = 5;
    localparam int ST_HPOL = 4;
    localparam int ST_VPOL = 3;
    localparam int ST_VEXT = 2;
    localparam int ST_HDET = 1;
    localparam int ST_VDET = 0;
    localparam logic [7:0] STATUS_RESET = 8'hD8;

    // Timing, clk at 25 MHz
    localparam int CLK_HZ = 25000000;
    localparam int GLITCH_NS = 50;
    localparam int GLITCH_CYC = (GLITCH_NS * (CLK_HZ / 1000000) + 999) / 1000 < 1 ? 1 :
        (GLITCH_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int DUTY_LIMIT_PCT = 25;

    // Sync sampling (link domain)
    typedef struct packed {
        logic line_pos;
        logic frame_pos;
        logic vext;
        logic line_det;
        logic frame_det;
    } sync_flags_t;

endpackage

// file: glitch_filter.sv
`timescale 1ns/1ns
module glitch_filter
    import sync_ctl_pkg::*;
#(
    parameter int CYC = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Synchronised input and filtered level
    input wire logic din,
    output logic dout
);
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic dout_ff;
    logic nxt_dout;

    // Output follows only after CYC+1 stable samples
    always_comb begin
        nxt_cnt = 8'h00;
        nxt_dout = dout_ff;
        if (din != dout_ff) begin
            if (cnt_ff >= 8'(CYC)) begin
                nxt_dout = din;
            end else begin
                nxt_cnt = cnt_ff + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_ff <= 8'h00;
            dout_ff <= 1'b1;
        end else begin
            cnt_ff <= nxt_cnt;
            dout_ff <= nxt_dout;
        end
    end

    assign dout = dout_ff;
endmodule // glitch_filter

// file: sync_detect.sv
`timescale 1ns/1ns
module sync_detect
    import sync_ctl_pkg::*;
#(
    parameter int WIN = 4096
) (
    // Link clock domain
    input wire logic sync_clk,
    input wire logic sync_rst,
    // Conditioned sync levels
    input wire logic line_or_composite_sync_in,
    input wire logic frame_sync_in,
    input wire logic refresh_tgl,
    // Results
    output sync_flags_t flags,
    output logic line_edge
);
    logic [1:0] l_sy_ff, f_sy_ff, r_sy_ff;
    logic l_prev_ff, f_prev_ff, r_prev_ff;
    logic [15:0] per_ff, hi_ff, f_hi_ff, f_per_ff;
    logic [15:0] nxt_per, nxt_hi, nxt_f_hi, nxt_f_per;
    sync_flags_t fl_ff, nxt_fl;
    logic edge_ff, nxt_edge;
    logic l_lvl, f_lvl, l_act, f_act;

    // Majority level is the idle level; active level is its opposite
    assign l_lvl = l_sy_ff[1];
    assign f_lvl = f_sy_ff[1];
    assign l_act = fl_ff.line_pos ? l_lvl : ~l_lvl;
    assign f_act = fl_ff.frame_pos ? f_lvl : ~f_lvl;

    // Period and pulse measurement, polarity and presence
    always_comb begin
        nxt_fl = fl_ff;
        nxt_per = per_ff + 16'h0001;
        nxt_hi = hi_ff + {15'h0000, l_lvl};
        nxt_f_per = f_per_ff + 16'h0001;
        nxt_f_hi = f_hi_ff + {15'h0000, f_lvl};
        nxt_edge = 1'b0;
        // Refresh first, so a same-cycle edge still sets
        if (r_sy_ff[1] != r_prev_ff) begin
            nxt_fl.vext = 1'b0;
            nxt_fl.line_det = 1'b0;
            nxt_fl.frame_det = 1'b0;
        end
        if (l_lvl != l_prev_ff) begin
            nxt_fl.line_det = 1'b1;
            // Leading edge of conditioned sync
            nxt_edge = (l_lvl == fl_ff.line_pos);
        end
        if (f_lvl != f_prev_ff) begin
            nxt_fl.frame_det = 1'b1;
        end
        // Edge into the active level leaves vext unchanged
        if (l_act && l_lvl != l_prev_ff) begin
            nxt_fl.vext = nxt_fl.vext;
        end
        if (per_ff == 16'(WIN)) begin
            // Polarity: high more than half the window means negative pulses
            nxt_fl.line_pos = (hi_ff < 16'(WIN / 2));
            // Duty above 25 percent of the window marks composite frame pulse
            if (hi_ff > 16'(WIN * DUTY_LIMIT_PCT / 100) &&
                hi_ff < 16'(WIN - WIN * DUTY_LIMIT_PCT / 100)) begin
                nxt_fl.vext = 1'b1;
            end
            nxt_per = 16'h0000;
            nxt_hi = 16'h0000;
        end
        if (f_per_ff == 16'(WIN)) begin
            nxt_fl.frame_pos = (f_hi_ff < 16'(WIN / 2));
            nxt_f_per = 16'h0000;
            nxt_f_hi = 16'h0000;
        end
        // Suppress line edges during an extracted frame pulse
        if (fl_ff.vext && l_act && hi_ff > 16'(WIN / 4)) begin
            nxt_edge = 1'b0;
        end
    end

    always_ff @(posedge sync_clk) begin
        if (sync_rst) begin
            l_sy_ff <= 2'h3;
            f_sy_ff <= 2'h3;
            r_sy_ff <= 2'h0;
            l_prev_ff <= 1'b1;
            f_prev_ff <= 1'b1;
            r_prev_ff <= 1'b0;
            per_ff <= 16'h0000;
            hi_ff <= 16'h0000;
            f_per_ff <= 16'h0000;
            f_hi_ff <= 16'h0000;
            fl_ff <= '0;
            edge_ff <= 1'b0;
        end else begin
            l_sy_ff <= {l_sy_ff[0], line_or_composite_sync_in};
            f_sy_ff <= {f_sy_ff[0], frame_sync_in};
            r_sy_ff <= {r_sy_ff[0], refresh_tgl};
            l_prev_ff <= l_lvl;
            f_prev_ff <= f_lvl;
            r_prev_ff <= r_sy_ff[1];
            per_ff <= nxt_per;
            hi_ff <= nxt_hi;
            f_per_ff <= nxt_f_per;
            f_hi_ff <= nxt_f_hi;
            fl_ff <= nxt_fl;
            edge_ff <= nxt_edge;
        end
    end

    assign flags = fl_ff;
    assign line_edge = edge_ff;
    wire unused_ok = f_act;
endmodule // sync_detect

// file: sync_status_serial_control.sv
`timescale 1ns/1ns
// Operation
// - Address 8C writes, 8D reads
// - Write: subaddress byte, then data byte
// - Extra data bytes auto-increment subaddress
// - Stop ends decoding, releases both lines
// - Read returns one status byte only
// - Status holds lock and protection flags
// - Top status bit zero when line locked
// - Two polarity flags, one means negative
// - Three presence flags, zero means absent
// - Written data applied at frame retrace
// - Outputs inhibited on low supplies
// - Low logic supply holds register defaults
// - Reject bus glitches under 50ns
// - Protection latch held until cleared
// - Lock pin high while line locked
// - Either line polarity, lead edge found but left unconnected
// - Extract frame pulse above 25% duty
// - Equalization pulses masked from the line edge, which is left open
// - Refresh bit restarts presence flags
// - Protection input sets inhibiting latch
module sync_status_serial_control
    import sync_ctl_pkg::*;
#(
    parameter int DET_WIN = 4096
) (
    // System clock and reset
    input wire logic clk,
    input wire logic srst,
    // Serial bus pins
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Sync link domain
    input wire logic sync_clk,
    input wire logic sync_rst,
    input wire logic line_or_composite_sync_in,
    input wire logic frame_sync_in,
    // Analog-side status inputs
    input wire logic line_locked_in,
    input wire logic frame_locked_in,
    input wire logic xray_in,
    input wire logic vcc_ok_in,
    input wire logic vdd_ok_in,
    input wire logic frame_retrace_in,
    // Outputs
    output logic line_lock_out_pin,
    output logic outputs_inhibit,
    output logic [7:0] active_regs [NUM_REGS]
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_ACK = 3'b010,
        S_WRB = 3'b011,
        S_RDB = 3'b100,
        S_RACK = 3'b101
    } bus_state_t;

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [1:0] scl_sy_ff, sda_sy_ff, lk_sy_ff, vl_sy_ff, xr_sy_ff;
    logic [1:0] vcc_sy_ff, vdd_sy_ff, rt_sy_ff;
    logic scl_f, sda_f, scl_d_ff, sda_d_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            scl_sy_ff <= 2'h3;
            sda_sy_ff <= 2'h3;
            lk_sy_ff <= 2'h0;
            vl_sy_ff <= 2'h0;
            xr_sy_ff <= 2'h0;
            vcc_sy_ff <= 2'h0;
            vdd_sy_ff <= 2'h0;
            rt_sy_ff <= 2'h0;
        end else begin
            scl_sy_ff <= {scl_sy_ff[0], scl_in};
            sda_sy_ff <= {sda_sy_ff[0], sda_in};
            lk_sy_ff <= {lk_sy_ff[0], line_locked_in};
            vl_sy_ff <= {vl_sy_ff[0], frame_locked_in};
            xr_sy_ff <= {xr_sy_ff[0], xray_in};
            vcc_sy_ff <= {vcc_sy_ff[0], vcc_ok_in};
            vdd_sy_ff <= {vdd_sy_ff[0], vdd_ok_in};
            rt_sy_ff <= {rt_sy_ff[0], frame_retrace_in};
        end
    end

    // Spike rejection on the bus lines
    glitch_filter #(.CYC(GLITCH_CYC)) u_scl_flt (
        .clk(clk), .srst(srst), .din(scl_sy_ff[1]), .dout(scl_f)
    );
    glitch_filter #(.CYC(GLITCH_CYC)) u_sda_flt (
        .clk(clk), .srst(srst), .din(sda_sy_ff[1]), .dout(sda_f)
    );

    ////////////////////////////////////////////////////////////////////
    // Sync detection in link domain, flags crossed back by two flops
    logic refresh_tgl_ff, nxt_refresh_tgl;
    sync_flags_t det_flags;
    sync_flags_t fl_s1_ff, fl_s2_ff;

    sync_detect #(.WIN(DET_WIN)) u_det (
        .sync_clk(sync_clk),
        .sync_rst(sync_rst),
        .line_or_composite_sync_in(line_or_composite_sync_in),
        .frame_sync_in(frame_sync_in),
        .refresh_tgl(refresh_tgl_ff),
        .flags(det_flags),
        .line_edge()
    );

    ////////////////////////////////////////////////////////////////////
    // Bus decoder
    bus_state_t st_ff, nxt_st;
    logic [7:0] sh_ff, nxt_sh;
    logic [3:0] bit_ff, nxt_bit;
    logic [1:0] byte_ff, nxt_byte;
    logic rd_ff, nxt_rd;
    logic sel_ff, nxt_sel;
    logic [3:0] sub_ff, nxt_sub;
    logic sda_oe_ff, nxt_sda_oe;
    logic [7:0] shadow_ff [NUM_REGS];
    logic [7:0] nxt_shadow [NUM_REGS];
    logic [7:0] act_ff [NUM_REGS];
    logic [7:0] nxt_act [NUM_REGS];
    logic pend_ff, nxt_pend;
    logic xray_ff, nxt_xray;
    logic [7:0] status;
    logic start_c, stop_c, rise, fall, logic_low, rt_rise, rt_d_ff;

    assign rise = scl_f & ~scl_d_ff;
    assign fall = ~scl_f & scl_d_ff;
    assign start_c = scl_f & scl_d_ff & sda_d_ff & ~sda_f;
    assign stop_c = scl_f & scl_d_ff & ~sda_d_ff & sda_f;
    assign logic_low = ~vdd_sy_ff[1];
    assign rt_rise = rt_sy_ff[1] & ~rt_d_ff;

    // Status byte assembly
    always_comb begin
        status = 8'h00;
        status[ST_HLOCK] = ~lk_sy_ff[1];
        status[ST_VLOCK] = ~vl_sy_ff[1];
        status[ST_XRAY] = xray_ff;
        status[ST_HPOL] = ~fl_s2_ff.line_pos;
        status[ST_VPOL] = ~fl_s2_ff.frame_pos;
        status[ST_VEXT] = fl_s2_ff.vext;
        status[ST_HDET] = fl_s2_ff.line_det;
        status[ST_VDET] = fl_s2_ff.frame_det;
    end

    // Protocol state machine and register writes
    always_comb begin
        nxt_st = st_ff;
        nxt_sh = sh_ff;
        nxt_bit = bit_ff;
        nxt_byte = byte_ff;
        nxt_rd = rd_ff;
        nxt_sel = sel_ff;
        nxt_sub = sub_ff;
        nxt_sda_oe = sda_oe_ff;
        nxt_shadow = shadow_ff;
        nxt_pend = pend_ff && !rt_rise;
        nxt_refresh_tgl = refresh_tgl_ff;
        if (stop_c) begin
            nxt_st = S_IDLE;
            nxt_sda_oe = 1'b0;
        end else if (start_c) begin
            nxt_st = S_ADDR;
            nxt_bit = 4'h0;
            nxt_byte = 2'h0;
            nxt_sda_oe = 1'b0;
        end else begin
            case (st_ff)
                S_ADDR, S_WRB: begin
                    if (rise) begin
                        nxt_sh = {sh_ff[6:0], sda_f};
                        nxt_bit = bit_ff + 4'h1;
                    end else if (fall && bit_ff == 4'h8) begin
                        nxt_st = S_ACK;
                        nxt_bit = 4'h0;
                        nxt_sda_oe = 1'b0;
                        if (st_ff == S_ADDR) begin
                            // Own address only
                            nxt_sel = (sh_ff == DEV_ADDR_WR) || (sh_ff == DEV_ADDR_RD);
                            nxt_rd = (sh_ff == DEV_ADDR_RD);
                            nxt_sda_oe = nxt_sel;
                        end else if (sel_ff && byte_ff == 2'h1) begin
                            nxt_sub = sh_ff[3:0];
                            nxt_sda_oe = 1'b1;
                        end else if (sel_ff) begin
                            nxt_shadow[sub_ff] = sh_ff;
                            nxt_sub = sub_ff + 4'h1;
                            nxt_pend = 1'b1;
                            if (sub_ff == SUB_REFRESH && sh_ff[CTL_BIT]) begin
                                nxt_refresh_tgl = ~refresh_tgl_ff;
                            end
                            nxt_sda_oe = 1'b1;
                        end
                        if (byte_ff != 2'h2) begin
                            nxt_byte = byte_ff + 2'h1;
                        end
                    end
                end
                S_ACK: begin
                    if (fall) begin
                        if (!sel_ff) begin
                            nxt_st = S_IDLE;
                            nxt_sda_oe = 1'b0;
                        end else if (rd_ff) begin
                            nxt_st = S_RDB;
                            nxt_sh = status;
                            nxt_sda_oe = ~status[7];
                        end else begin
                            nxt_st = S_WRB;
                            nxt_sda_oe = 1'b0;
                        end
                    end
                end
                S_RDB: begin
                    if (fall) begin
                        nxt_bit = bit_ff + 4'h1;
                        nxt_sh = {sh_ff[6:0], 1'b0};
                        nxt_sda_oe = ~sh_ff[6];
                        if (bit_ff == 4'h7) begin
                            nxt_st = S_RACK;
                            nxt_sda_oe = 1'b0;
                        end
                    end
                end
                S_RACK: begin
                    // Only one byte is ever returned
                    if (fall) begin
                        nxt_st = S_IDLE;
                    end
                end
                default: begin
                    nxt_st = S_IDLE;
                end
            endcase
        end
        if (logic_low) begin
            nxt_shadow = REG_DEFAULTS;
            nxt_st = S_IDLE;
            nxt_sda_oe = 1'b0;
            nxt_pend = 1'b0;
        end
    end

    // Transfer shadow to active registers at retrace
    always_comb begin
        nxt_act = act_ff;
        if (logic_low) begin
            nxt_act = REG_DEFAULTS;
        end else if (rt_rise && pend_ff) begin
            nxt_act = shadow_ff;
        end
    end

    // Protection latch: set wins over reset
    always_comb begin
        nxt_xray = xray_ff;
        if (xr_sy_ff[1]) begin
            nxt_xray = 1'b1;
        end else if (~vcc_sy_ff[1] || logic_low) begin
            nxt_xray = 1'b0;
        end else if (rt_rise && pend_ff && shadow_ff[SUB_XRAY][CTL_BIT]) begin
            nxt_xray = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_ff <= S_IDLE;
            sh_ff <= 8'h00;
            bit_ff <= 4'h0;
            byte_ff <= 2'h0;
            rd_ff <= 1'b0;
            sel_ff <= 1'b0;
            sub_ff <= 4'h0;
            sda_oe_ff <= 1'b0;
            shadow_ff <= REG_DEFAULTS;
            act_ff <= REG_DEFAULTS;
            pend_ff <= 1'b0;
            xray_ff <= 1'b0;
            refresh_tgl_ff <= 1'b0;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            rt_d_ff <= 1'b0;
            fl_s1_ff <= '0;
            fl_s2_ff <= '0;
            line_lock_out_pin <= 1'b0;
            outputs_inhibit <= 1'b1;
        end else begin
            st_ff <= nxt_st;
            sh_ff <= nxt_sh;
            bit_ff <= nxt_bit;
            byte_ff <= nxt_byte;
            rd_ff <= nxt_rd;
            sel_ff <= nxt_sel;
            sub_ff <= nxt_sub;
            sda_oe_ff <= nxt_sda_oe;
            shadow_ff <= nxt_shadow;
            act_ff <= nxt_act;
            pend_ff <= nxt_pend;
            xray_ff <= nxt_xray;
            refresh_tgl_ff <= nxt_refresh_tgl;
            scl_d_ff <= scl_f;
            sda_d_ff <= sda_f;
            rt_d_ff <= rt_sy_ff[1];
            fl_s1_ff <= det_flags;
            fl_s2_ff <= fl_s1_ff;
            line_lock_out_pin <= lk_sy_ff[1];
            outputs_inhibit <= ~vcc_sy_ff[1] | ~vdd_sy_ff[1] | nxt_xray;
        end
    end

    // Pin drivers: data pulls low only, clock never driven
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_ff;
    assign scl_out = 1'b0;
    assign scl_oe = 1'b0;
    assign active_regs = act_ff;
endmodule // sync_status_serial_control

// file: sync_ctl_asserts.sv
`timescale 1ns/1ns
module sync_ctl_asserts
    import sync_ctl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic scl_oe,
    input wire logic sda_oe,
    // Status and supplies
    input wire logic line_locked_in,
    input wire logic xray_in,
    input wire logic vcc_ok_in,
    input wire logic vdd_ok_in,
    input wire logic frame_retrace_in,
    // Outputs
    input wire logic line_lock_out_pin,
    input wire logic outputs_inhibit,
    input wire logic [7:0] active_regs [NUM_REGS]
);
    logic [127:0] reg_flat;
    logic [127:0] def_flat;
    logic [3:0] since_ff;
    logic [3:0] nxt_since;
    logic rtr_ff;
    logic nxt_rtr;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Flat views of the applied and default registers
    assign reg_flat = {>>{active_regs}};
    assign def_flat = {>>{REG_DEFAULTS}};

    // Cycles since the last retrace rise or low logic supply, saturating
    always_comb begin
        nxt_rtr = frame_retrace_in;
        nxt_since = (since_ff == 4'hF) ? since_ff : since_ff + 4'h1;
        if ((frame_retrace_in && !rtr_ff) || !vdd_ok_in || srst) begin
            nxt_since = 4'h0;
        end
    end
    always_ff @(posedge clk) begin
        rtr_ff <= nxt_rtr;
        since_ff <= nxt_since;
    end

    ////////////////////////////////////////
    chk_lock_high: assert property (line_locked_in [*5] |-> line_lock_out_pin)
        else $error("lock pin low while loop locked");
    chk_lock_low: assert property (!line_locked_in [*5] |-> !line_lock_out_pin)
        else $error("lock pin high while loop unlocked");
    chk_supply_inhibit: assert property ((!vcc_ok_in || !vdd_ok_in) |-> ##[1:6] outputs_inhibit)
        else $error("outputs not inhibited on low supply");
    chk_xray_set: assert property ($rose(xray_in) |-> ##[1:6] outputs_inhibit)
        else $error("protection input did not inhibit");
    chk_latch_hold: assert property ($fell(outputs_inhibit) |-> !$past(xray_in))
        else $error("inhibit dropped while protection active");
    chk_scl_free: assert property (!scl_oe)
        else $error("clock line driven");
    chk_stop_release: assert property (scl_in && $rose(sda_in) |-> !sda_oe [*8])
        else $error("data line driven after stop");
    chk_sda_low_phase: assert property ($changed(sda_oe) && vdd_ok_in |-> !scl_in)
        else $error("data changed while clock high");
    chk_low_vdd_defaults: assert property (!vdd_ok_in [*4] |-> reg_flat == def_flat)
        else $error("registers not at defaults on low logic supply");
    chk_apply_retrace: assert property (!$stable(reg_flat) |-> since_ff < 4'hA)
        else $error("registers changed away from retrace");
endmodule // sync_ctl_asserts

bind sync_status_serial_control sync_ctl_asserts chk_i (
    .clk(clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in), .scl_oe(scl_oe),
    .sda_oe(sda_oe), .line_locked_in(line_locked_in), .xray_in(xray_in),
    .vcc_ok_in(vcc_ok_in), .vdd_ok_in(vdd_ok_in), .frame_retrace_in(frame_retrace_in),
    .line_lock_out_pin(line_lock_out_pin), .outputs_inhibit(outputs_inhibit),
    .active_regs(active_regs)
);

// file: serial_host.sv
`timescale 1ns/1ns
module serial_host (
    // Pacing clock
    input wire logic clk,
    // Wired data level and open-drain drives
    input wire logic sda,
    output logic scl_drv,
    output logic sda_drv
);
    localparam int Q = 16; // Quarter bit, 64 clocks a bit keeps under 400 kHz
    logic glitch = 1'b0;

    // Both lines released at start
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    // Wait quarter bits, moving only after falling edges
    task automatic q(input int n);
        repeat (n * Q) @(negedge clk);
    endtask
    // Start or repeated start, address byte follows
    task automatic start;
        sda_drv = 1'b1;
        q(1);
        scl_drv = 1'b1;
        q(1);
        sda_drv = 1'b0;
        q(1);
        scl_drv = 1'b0;
        q(1);
    endtask
    // Stop: data rises with clock high
    task automatic stop;
        sda_drv = 1'b0;
        q(1);
        scl_drv = 1'b1;
        q(1);
        sda_drv = 1'b1;
        q(1);
    endtask
    // One bit, with an optional 40 ns clock spike in the low phase
    task automatic xbit(input logic b, output logic r);
        sda_drv = b;
        if (glitch) begin
            @(negedge clk);
            scl_drv = 1'b1;
            @(negedge clk);
            scl_drv = 1'b0;
        end
        q(1);
        scl_drv = 1'b1;
        q(1);
        r = sda;
        q(1);
        scl_drv = 1'b0;
        q(1);
    endtask
    // Byte out MSB first, ack is the ninth bit pulled low
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(v[i], r);
        xbit(1'b1, r);
        ack = !r;
    endtask
    // Single byte in, then not-acknowledge
    task automatic rbyte(output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, r);
            v[i] = r;
        end
        xbit(1'b1, r);
    endtask
endmodule // serial_host

// file: test_sync_status_serial_control.sv
`timescale 1ns/1ns
module test_sync_status_serial_control;
    import sync_ctl_pkg::*;
    logic clk = 0, srst = 1, sync_clk = 0, sync_rst = 1, lsync = 1, fsync = 1;
    logic ll = 0, fl = 0, xr_in = 0, vcc = 1, vdd = 1, rtr = 0, xr = 0, ack;
    logic scl_h, sda_h, scl_oe, scl_out, sda_oe, sda_out, lock_pin, inhibit, scl, sda;
    logic [7:0] areg [NUM_REGS];
    logic [7:0] mreg [NUM_REGS];
    logic [7:0] mpend [NUM_REGS];
    logic [7:0] d;
    logic [6:0] sc = 7'h00;
    logic [4:0] det = 5'h18;
    int failures = 0, cmp_count = 0, cyc = 0, seed = 14, mode = 0;

    // Wired-AND bus lines
    assign scl = scl_h & !(scl_oe & !scl_out);
    assign sda = sda_h & !(sda_oe & !sda_out);

    sync_status_serial_control #(.DET_WIN(64)) DUT (
        .clk(clk), .srst(srst), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .sync_clk(sync_clk),
        .sync_rst(sync_rst), .line_or_composite_sync_in(lsync), .frame_sync_in(fsync),
        .line_locked_in(ll), .frame_locked_in(fl), .xray_in(xr_in), .vcc_ok_in(vcc),
        .vdd_ok_in(vdd), .frame_retrace_in(rtr), .line_lock_out_pin(lock_pin),
        .outputs_inhibit(inhibit), .active_regs(areg));
    serial_host host (.clk(clk), .sda(sda), .scl_drv(scl_h), .sda_drv(sda_h));

    // System and link clocks
    initial begin
        forever #20 clk = !clk;
    end
    initial begin
        #7;
        forever #15 sync_clk = !sync_clk;
    end
    // Sync patterns: 1 separate, 2 composite with wide frame pulses
    always @(negedge sync_clk) begin
        sc <= sc + 7'h01;
        lsync <= (mode == 1) ? sc[3:0] < 4'h2 :
            (mode == 2) ? sc[3:0] >= (sc[6] == 1'b0 ? 4'h6 : 4'h2) : 1'b1;
        fsync <= (mode == 1) ? sc[4:0] >= 5'h02 : 1'b1;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            failures++;
            end_of_test;
        end
    end

    ////////////////////////////////////////
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test;
        if (failures == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic cregs;
        for (int i = 0; i < NUM_REGS; i++) chk("register", areg[i], mreg[i]);
    endtask
    task automatic wr(input logic [3:0] sub, input logic [7:0] v);
        host.start;
        host.wbyte(DEV_ADDR_WR, ack);
        chk("address ack", ack, 8'h01);
        host.wbyte({4'h0, sub}, ack);
        chk("subaddress ack", ack, 8'h01);
        host.wbyte(v, ack);
        chk("data ack", ack, 8'h01);
        host.stop;
        mpend[sub] = v;
    endtask
    task automatic retr;
        rtr = 1;
        w(4);
        rtr = 0;
        w(8);
        mreg = mpend;
        if (mpend[1][7]) xr = 0;
    endtask
    task automatic rd_stat;
        host.start;
        host.wbyte(DEV_ADDR_RD, ack);
        chk("read ack", ack, 8'h01);
        host.rbyte(d);
        host.stop;
        chk("status", d, {!ll, !fl, xr, det});
    endtask

    ////////////////////////////////////////
    initial begin
        mreg = REG_DEFAULTS;
        mpend = REG_DEFAULTS;
        w(3);
        srst = 0;
        sync_rst = 0;
        w(4);
        cregs;
        rd_stat;
        // Burst wrapping past the top subaddress
        host.start;
        host.wbyte(DEV_ADDR_WR, ack);
        host.wbyte(8'h0E, ack);
        for (int i = 0; i < 3; i++) begin
            d = 8'($random(seed));
            host.wbyte(d, ack);
            chk("burst ack", ack, 8'h01);
            mpend[(14 + i) % 16] = d;
        end
        host.stop;
        cregs;
        retr;
        cregs;
        // Foreign address is ignored
        host.start;
        host.wbyte(8'h8E, ack);
        chk("foreign ack", ack, 8'h00);
        host.stop;
        repeat (4) begin
            {ll, fl} = 2'($random(seed));
            w(8);
            chk("lock pin", lock_pin, ll);
            rd_stat;
        end
        // Short clock spikes are filtered
        host.glitch = 1;
        wr(4'h5, 8'($random(seed)));
        host.glitch = 0;
        retr;
        cregs;
        // Protection latch, cleared by a write applied at retrace
        xr_in = 1;
        w(4);
        xr_in = 0;
        xr = 1;
        w(8);
        chk("inhibit", inhibit, 8'h01);
        rd_stat;
        wr(4'h1, 8'h80);
        chk("inhibit", inhibit, 8'h01);
        retr;
        chk("inhibit", inhibit, 8'h00);
        wr(4'h1, 8'h00);
        retr;
        // Supply drops
        xr_in = 1;
        w(4);
        xr_in = 0;
        vdd = 0;
        w(8);
        chk("inhibit", inhibit, 8'h01);
        mreg = REG_DEFAULTS;
        mpend = REG_DEFAULTS;
        xr = 0;
        cregs;
        vdd = 1;
        w(8);
        chk("inhibit", inhibit, 8'h00);
        vcc = 0;
        w(8);
        chk("inhibit", inhibit, 8'h01);
        vcc = 1;
        w(8);
        // Sync identification after refresh
        mode = 1;
        w(300);
        wr(4'h4, 8'h80);
        w(1000);
        det = 5'h0B;
        rd_stat;
        wr(4'h3, 8'h80);
        mode = 2;
        w(300);
        wr(4'h4, 8'h80);
        w(1000);
        det = 5'h1E;
        rd_stat;
        end_of_test;
    end
endmodule // test_sync_status_serial_control
